// ---- core/wdt_pkg.sv ----
// package of constants and types for the watchdog reset timer
package wdt_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is index times four)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CSR = 16'hFFBE;
  localparam logic [15:0] IDX_CNT = 16'hFFBF;
  localparam logic [15:0] IDX_EVT = 16'hFFC0;
  localparam logic [15:0] IDX_MASK = 16'hFFC1;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 17;

  // ----------------------------------------------------------------
  // control/status bit positions
  // ----------------------------------------------------------------
  localparam int KEY_CWE = 7;
  localparam int POS_CWE = 6;
  localparam int KEY_RWE = 5;
  localparam int POS_RWE = 4;
  localparam int KEY_WATCHDOG_ENABLE = 3;
  localparam int POS_WATCHDOG_ENABLE = 2;
  localparam int KEY_RESET_CAUSE_FLAG = 1;
  localparam int POS_RESET_CAUSE_FLAG = 0;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_RESET = 8'hAA;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int DIV_RATIO_DEF = 8192;
  localparam int PRE_W = 13;
  localparam int RST_OSC_CYCLES = 512;
  localparam logic [8:0] RST_LAST = 9'(RST_OSC_CYCLES - 1);
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE = 1;

  // ----------------------------------------------------------------
  // event bits of the interrupt status and mask registers
  // ----------------------------------------------------------------
  localparam int EVT_W = 2;
  localparam int EVT_OVF = 0;
  localparam int EVT_REFUSED = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cwe;
    logic rwe;
    logic watchdog_enable;
    logic reset_cause_flag;
  } csr_t;

  localparam csr_t CSR_FIELDS_RESET = '{cwe: 1'b0, rwe: 1'b0, watchdog_enable: 1'b0, reset_cause_flag: 1'b0};

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] idx;
  } acc_t;

  typedef enum logic {
    WD_NORMAL = 1'b0,
    WD_PULSE = 1'b1
  } wd_state_t;

endpackage

// ---- core/watchdog_reset_timer.sv ----
// watchdog reset timer with key-protected control register, AHB-Lite slave
//
// Summary of operation
// - key bits 7,5,3,1 always read one and never store written data
// - counter write enable changes only on reset or when bit 7 written zero alongside
// - counter loads on write only while counter write enable is one
// - register write enable gates every write to bits 2 and 0
// - enable sets on write bit3=0, bit2=1 with register write enable one
// - enable clears on reset or write bit3=0, bit2=0 under register write enable
// - counter counts only while watchdog enable is one
// - eight-bit up-counter advances once per clock/8192 tick
// - wrap from FF to 00 raises internal reset and sets reset cause
// - overflow reset goes chip-wide, not only to this block
// - overflow reset pulse lasts 512 oscillator cycles
// - reset cause flag set whenever overflow produces internal reset
// - cause flag clears on pin reset or write bit1=0, bit0=0 under enable
// - counting resumes upward from a written counter value
// - counter resets to 00, control register to AA
// - in low-power modes counter halts and control register holds
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_timer #(
  parameter int DIV_RATIO = wdt_pkg::DIV_RATIO_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // chip side
  input wire logic external_reset_pin_n,
  input wire logic low_power_halt,
  output logic chip_reset,
  output logic irq
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acc_t acc_q, acc_d;
  logic late_q, late_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic hresp_q;
  csr_t csr_q, csr_d;
  logic [7:0] cnt_q, cnt_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  wd_state_t state_q, state_d;
  logic [8:0] rcnt_q, rcnt_d;
  logic chip_reset_q, chip_reset_d;
  logic [EVT_W-1:0] evt_q, evt_d;
  logic [EVT_W-1:0] mask_q, mask_d;
  logic irq_q, irq_d;
  logic pin_meta_q, pin_sync_q;
  logic take;
  logic mapped;
  logic wr_go;
  logic [7:0] wd;
  logic wr_csr, wr_cnt, wr_evt, wr_mask;
  logic tick;
  logic ovf;
  logic refused;
  logic [EVT_W-1:0] evt_set;

  // ----------------------------------------------------------------
  // register read value
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_value(input logic [15:0] idx);
    logic [31:0] v;
    v = '0;
    case (idx)
      IDX_CSR: begin
        v[KEY_CWE] = 1'b1;
        v[POS_CWE] = csr_q.cwe;
        v[KEY_RWE] = 1'b1;
        v[POS_RWE] = csr_q.rwe;
        v[KEY_WATCHDOG_ENABLE] = 1'b1;
        v[POS_WATCHDOG_ENABLE] = csr_q.watchdog_enable;
        v[KEY_RESET_CAUSE_FLAG] = 1'b1;
        v[POS_RESET_CAUSE_FLAG] = csr_q.reset_cause_flag;
      end
      IDX_CNT: v[7:0] = cnt_q;
      IDX_EVT: v[EVT_W-1:0] = evt_q;
      IDX_MASK: v[EVT_W-1:0] = mask_q;
      default: v = '0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // external reset pin synchroniser
  // ----------------------------------------------------------------
  // pin is asynchronous to hclk, so two flops before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= external_reset_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // address phase decode; only whole aligned words are mapped
  assign take = hsel && htrans[HTRANS_ACTIVE] && hready;
  assign mapped = (haddr[31:IDX_MSB+1] == '0) && (haddr[IDX_LSB-1:0] == '0)
                  && (hsize == HSIZE_WORD);
  assign wr_go = acc_q.valid && acc_q.write && hreadyout_q;
  assign wd = hwdata[7:0];
  assign wr_csr = wr_go && (acc_q.idx == IDX_CSR);
  assign wr_cnt = wr_go && (acc_q.idx == IDX_CNT);
  assign wr_evt = wr_go && (acc_q.idx == IDX_EVT);
  assign wr_mask = wr_go && (acc_q.idx == IDX_MASK);

  // a read right behind a write waits one cycle so it sees the write
  always_comb begin
    acc_d = acc_q;
    late_d = 1'b0;
    hrdata_d = hrdata_q;
    hreadyout_d = 1'b1;
    if (late_q) begin
      hrdata_d = rd_value(acc_q.idx);
    end else if (hready) begin
      acc_d = '0;
      if (take) begin
        acc_d.valid = 1'b1;
        acc_d.write = hwrite;
        acc_d.idx = mapped ? haddr[IDX_MSB:IDX_LSB] : '0;
        if (!hwrite) begin
          if (wr_go) begin
            late_d = 1'b1;
            hreadyout_d = 1'b0;
          end else begin
            hrdata_d = mapped ? rd_value(haddr[IDX_MSB:IDX_LSB]) : '0;
          end
        end
      end
    end
  end

  // bus registers; response is always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= '0;
      late_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      late_q <= late_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      hresp_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // divider, held in low-power halt and cleared during the reset pulse
  always_comb begin
    pre_d = pre_q;
    tick = 1'b0;
    if (state_q == WD_PULSE) begin
      pre_d = '0;
    end else if (!low_power_halt) begin
      if (pre_q == PRE_W'(DIV_RATIO - 1)) begin
        pre_d = '0;
        tick = 1'b1;
      end else begin
        pre_d = PRE_W'(pre_q + 1'b1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a bus load takes precedence over a tick in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    ovf = 1'b0;
    refused = wr_cnt && !csr_q.cwe;
    if (state_q == WD_PULSE) begin
      cnt_d = CNT_RESET;
    end else if (wr_cnt && csr_q.cwe) begin
      cnt_d = wd;
    end else if (tick && csr_q.watchdog_enable) begin
      cnt_d = 8'(cnt_q + 1'b1);
      ovf = (cnt_q == CNT_MAX);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // control/status register
  // ----------------------------------------------------------------
  // key bits are not stored at all, so they cannot hold a written value
  always_comb begin
    csr_d = csr_q;
    if (wr_csr && !low_power_halt) begin
      if (!wd[KEY_CWE]) begin
        csr_d.cwe = wd[POS_CWE];
      end
      if (!wd[KEY_RWE]) begin
        csr_d.rwe = wd[POS_RWE];
      end
      // gate on bits 2 and 0
      if (csr_q.rwe) begin
        if (!wd[KEY_WATCHDOG_ENABLE]) begin
          csr_d.watchdog_enable = wd[POS_WATCHDOG_ENABLE];
        end
        if (!wd[KEY_RESET_CAUSE_FLAG] && !wd[POS_RESET_CAUSE_FLAG]) begin
          csr_d.reset_cause_flag = 1'b0;
        end
      end
    end
    if (!pin_sync_q) begin
      csr_d.reset_cause_flag = 1'b0;
    end
    // internal reset clears control bits but keeps the cause
    if (state_q == WD_PULSE) begin
      csr_d.cwe = 1'b0;
      csr_d.rwe = 1'b0;
      csr_d.watchdog_enable = 1'b0;
    end
    if (ovf) begin
      csr_d.reset_cause_flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csr_q <= CSR_FIELDS_RESET;
    end else begin
      csr_q <= csr_d;
    end
  end

  // ----------------------------------------------------------------
  // internal reset pulse
  // ----------------------------------------------------------------
  // pulse of fixed length
  always_comb begin
    state_d = state_q;
    rcnt_d = rcnt_q;
    chip_reset_d = chip_reset_q;
    case (state_q)
      WD_NORMAL: begin
        if (ovf) begin
          state_d = WD_PULSE;
          rcnt_d = RST_LAST;
          chip_reset_d = 1'b1;
        end
      end
      WD_PULSE: begin
        if (rcnt_q == '0) begin
          state_d = WD_NORMAL;
          chip_reset_d = 1'b0;
        end else begin
          rcnt_d = 9'(rcnt_q - 1'b1);
        end
      end
      default: begin
        state_d = WD_NORMAL;
        chip_reset_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= WD_NORMAL;
      rcnt_q <= '0;
      chip_reset_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rcnt_q <= rcnt_d;
      chip_reset_q <= chip_reset_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // write one clears; a new event in the same cycle still sets
  always_comb begin
    evt_set = '0;
    evt_set[EVT_OVF] = ovf;
    evt_set[EVT_REFUSED] = refused;
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = evt_q & ~wd[EVT_W-1:0];
    end
    evt_d = evt_d | evt_set;
    mask_d = wr_mask ? wd[EVT_W-1:0] : mask_q;
    irq_d = |(evt_d & mask_d);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign chip_reset = chip_reset_q;
  assign irq = irq_q;

endmodule

`default_nettype wire

// ---- verif/wdt_chk.sv ----
// checker of bus answers and reset pulse timing for the watchdog timer
`timescale 1ns/1ps
`default_nettype none

module wdt_chk #(
  parameter int DIV_RATIO = wdt_pkg::DIV_RATIO_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // chip side
  input wire logic low_power_halt,
  input wire logic chip_reset,
  input wire logic irq
);
  import wdt_pkg::*;
  logic [9:0] pulse_q;
  logic [9:0] pulse_d;
  logic rd_taken;
  logic csr_rd;
  logic bad_rd;

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  // cycles the current chip reset has stood so far
  always_comb begin
    pulse_d = chip_reset ? pulse_q + 10'd1 : 10'd0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_q <= 10'd0;
    end else begin
      pulse_q <= pulse_d;
    end
  end
  // read address phases; indices below the control word are unmapped
  assign rd_taken = hsel && htrans[1] && hready && !hwrite;
  assign csr_rd = rd_taken && hsize == HSIZE_WORD && haddr == {14'h0, IDX_CSR, 2'b00};
  assign bad_rd = rd_taken && haddr[17:2] < IDX_CSR;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_reset_quiet:
    assert property ($rose(hresetn) |-> !chip_reset && !irq) else $error("outputs busy at release");
  a_key_bits_one:
    assert property (csr_rd |=> ##[0:1] (hreadyout && (hrdata[7:0] & 8'hAA) == 8'hAA))
    else $error("key bit read as zero");
  a_unmapped_zero:
    assert property (bad_rd |=> ##[0:1] (hreadyout && hrdata == 32'h0))
    else $error("unmapped read not zero");
  a_pulse_len:
    assert property ($fell(chip_reset) |-> pulse_q == 10'(RST_OSC_CYCLES))
    else $error("chip reset pulse too short");
  a_pulse_bound:
    assert property (chip_reset |-> pulse_q < 10'(RST_OSC_CYCLES)) else $error("pulse too long");
  a_halt_no_reset:
    assert property ($rose(chip_reset) |-> !$past(low_power_halt)) else $error("reset while halted");
  a_write_no_wait:
    assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  a_hresp_okay:
    assert property (hresp == 1'b0) else $error("error response");

  // main scenarios reached
  c_overflow: cover property ($rose(chip_reset));
  c_unmapped: cover property (bad_rd);
  c_irq: cover property ($rose(irq));
endmodule

bind watchdog_reset_timer wdt_chk #(.DIV_RATIO(DIV_RATIO)) wdt_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .low_power_halt(low_power_halt),
  .chip_reset(chip_reset), .irq(irq)
);
`default_nettype wire

// ---- verif/chip_reset_model.sv ----
// model of the chip reset logic that surrounds the watchdog
`timescale 1ns/1ps
`default_nettype none

module chip_reset_model (
  // clock
  input wire logic hclk,
  // from watchdog and bench
  input wire logic chip_reset,
  input wire logic pin_hold,
  // to watchdog and bench
  output logic external_reset_pin_n,
  output int pulse_len
);
  int run = 0;
  // pin pressed while the bench holds it
  assign external_reset_pin_n = !pin_hold;
  // width of the last chip-wide reset, kept until the next one ends
  always @(posedge hclk) begin
    run <= chip_reset ? run + 1 : 0;
    if (!chip_reset && run != 0) begin
      pulse_len <= run;
    end
  end
endmodule
`default_nettype wire

// ---- verif/watchdog_reset_timer_tb.sv ----
// self-checking testbench of the watchdog reset timer
`timescale 1ns/1ps
`default_nettype none

module watchdog_reset_timer_tb;
  import wdt_pkg::*;
  localparam int DIV = 8;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic low_power_halt = 1'b0;
  logic pin_hold = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, external_reset_pin_n, chip_reset, irq;
  int pulse_len;
  int mismatches = 0;
  int n_compared = 0;

  always #2.5 hclk = ~hclk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  watchdog_reset_timer #(.DIV_RATIO(DIV)) watchdog_reset_timer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_reset_pin_n(external_reset_pin_n),
    .low_power_halt(low_power_halt), .chip_reset(chip_reset), .irq(irq)
  );
  chip_reset_model chip_reset_model_inst (
    .hclk(hclk), .chip_reset(chip_reset), .pin_hold(pin_hold),
    .external_reset_pin_n(external_reset_pin_n), .pulse_len(pulse_len)
  );

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, i, 2'b00};
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(negedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic rchk(input string n, input logic [15:0] i, input logic [31:0] e);
    bus(1'b0, i, 8'h0);
    chk(n, e, rd);
  endtask
  // irq is registered, so give it two edges to settle
  task automatic irq_chk(input logic e);
    repeat (2) @(negedge hclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge hclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rchk("csr", IDX_CSR, 32'hAA); // control reset value
    rchk("cnt", IDX_CNT, 32'h0); // counter reset value
    rchk("unmapped", 16'h0001, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_keys;
    bus(1'b1, IDX_CNT, 8'h10);
    rchk("cnt locked", IDX_CNT, 32'h0); // load refused
    rchk("evt", IDX_EVT, 32'h2);
    bus(1'b1, IDX_MASK, 8'h2);
    irq_chk(1'b1);
    bus(1'b1, IDX_MASK, 8'h0);
    irq_chk(1'b0);
    bus(1'b1, IDX_EVT, 8'h2);
    bus(1'b1, IDX_MASK, 8'h2);
    irq_chk(1'b0);
    bus(1'b1, IDX_CSR, 8'h40);
    rchk("csr cwe", IDX_CSR, 32'hEA); // key written zero
    bus(1'b1, IDX_CSR, 8'hB4);
    rchk("csr gated", IDX_CSR, 32'hEA); // write ignored
    bus(1'b1, IDX_CNT, 8'h10);
    rchk("cnt load", IDX_CNT, 32'h10); // load accepted
    $display("test keys done");
  endtask
  task automatic t_overflow;
    bus(1'b1, IDX_CSR, 8'hD0);
    rchk("csr rwe", IDX_CSR, 32'hFA); // write enable set
    bus(1'b1, IDX_CSR, 8'hF4);
    rchk("csr on", IDX_CSR, 32'hFE); // enable set
    bus(1'b1, IDX_CNT, 8'hFE);
    for (int k = 0; k < 100 && chip_reset !== 1'b1; k++) @(negedge hclk);
    chk("reset rose", 32'h1, {31'h0, chip_reset}); // wrap after two ticks
    for (int k = 0; k < 600 && chip_reset !== 1'b0; k++) @(negedge hclk);
    repeat (2) @(posedge hclk);
    chk("pulse len", 32'd512, pulse_len); // pulse width
    rchk("csr cause", IDX_CSR, 32'hAB); // flag set, controls cleared
    rchk("cnt wrap", IDX_CNT, 32'h0); // counter wrapped
    rchk("evt ovf", IDX_EVT, 32'h1);
    irq_chk(1'b0);
    $display("test overflow done");
  endtask
  task automatic t_pin;
    pin_hold <= 1'b1;
    repeat (5) @(posedge hclk);
    pin_hold <= 1'b0;
    rchk("csr pin", IDX_CSR, 32'hAA); // pin clears flag
    $display("test pin done");
  endtask
  task automatic t_halt;
    logic [31:0] v;
    bus(1'b1, IDX_CSR, 8'h54);
    rchk("csr old rwe", IDX_CSR, 32'hFA); // gate uses old value
    bus(1'b1, IDX_CSR, 8'hF4);
    low_power_halt <= 1'b1;
    bus(1'b0, IDX_CNT, 8'h0);
    v = rd;
    repeat (40) @(posedge hclk);
    rchk("cnt halted", IDX_CNT, v); // counter halted
    bus(1'b1, IDX_CSR, 8'hF0);
    rchk("csr held", IDX_CSR, 32'hFE); // control retained
    low_power_halt <= 1'b0;
    repeat (40) @(posedge hclk);
    bus(1'b0, IDX_CNT, 8'h0);
    chk("cnt rate", 32'h1, {31'h0, rd > v + 32'd3 && rd < v + 32'd8}); // tick rate
    bus(1'b1, IDX_CSR, 8'hF0);
    rchk("csr off", IDX_CSR, 32'hFA); // enable cleared
    bus(1'b0, IDX_CNT, 8'h0);
    v = rd;
    repeat (40) @(posedge hclk);
    rchk("cnt stopped", IDX_CNT, v); // counting stops
    $display("test halt done");
  endtask
  // second overflow, then the cause flag cleared by software
  task automatic t_clear;
    bus(1'b1, IDX_CNT, 8'hFF);
    bus(1'b1, IDX_CSR, 8'hF4);
    for (int k = 0; k < 100 && chip_reset !== 1'b1; k++) @(negedge hclk);
    chk("reset rose 2", 32'h1, {31'h0, chip_reset}); // wrap on next tick
    for (int k = 0; k < 600 && chip_reset !== 1'b0; k++) @(negedge hclk);
    @(posedge hclk);
    rchk("csr cause 2", IDX_CSR, 32'hAB); // flag set again
    bus(1'b1, IDX_CSR, 8'hF8);
    rchk("csr clr gated", IDX_CSR, 32'hAB); // clear needs write enable
    bus(1'b1, IDX_CSR, 8'hD0);
    rchk("csr rwe 2", IDX_CSR, 32'hBB); // write enable set
    bus(1'b1, IDX_CSR, 8'hFD);
    rchk("csr clr half", IDX_CSR, 32'hBB); // both bits must be zero
    bus(1'b1, IDX_CSR, 8'hF8);
    rchk("csr clr sw", IDX_CSR, 32'hBA); // software clear
    $display("test clear done");
  endtask

  // ------------------------------------------------------------
  // sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_keys();
    t_overflow();
    t_pin();
    t_halt();
    t_clear();
    test_done();
  end
  // the run needs about 1300 cycles; far beyond that it has hung
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    $display("[ERR] run expected finish seen timeout");
    test_done();
  end
endmodule
`default_nettype wire
